// >>> hdl/ibac_pkg.sv
// Shared constants, types and decode helpers of the internal bus access block
package ibac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;             // CPU address width
  localparam int BYTE_W = 8;              // Internal bus data width
  localparam int WORD_W = 16;             // CPU word width

  // ----------------------------------------------------------------
  // Register map (byte addresses on AXI4-Lite)
  // ----------------------------------------------------------------
  localparam logic [31:0] PMC_OFFSET  = 32'h0000_0004; // Mode control
  localparam logic [31:0] STAT_OFFSET = 32'h0000_0008; // Sequencer status
  localparam logic [7:0]  PMC_RESET   = 8'h00;         // Mode reset value
  localparam int          PMC_SWRST   = 3;             // Reset trigger bit
  localparam int          PMC_RSV_MSB = 2;             // Reserved b2..b0
  localparam int          STAT_BUSY   = 0;             // Busy flag
  localparam int          STAT_AREA_L = 1;             // Last area low bit
  localparam int          STAT_AREA_H = 2;             // Last area high bit
  localparam int          STAT_FAULT  = 3;             // Sticky fault

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Single-chip address map
  // ----------------------------------------------------------------
  localparam logic [15:0] SFR_LAST = 16'h02FF;  // SFR from zero up
  localparam logic [15:0] RAM_BASE = 16'h0400;  // Internal RAM start
  localparam logic [15:0] RAM_LAST = 16'h0BFF;  // Internal RAM end
  localparam logic [15:0] ROM_BASE = 16'h4000;  // Internal ROM to top
  localparam logic [15:0] ADDR_INC = 16'h0001;  // Second byte step

  // Bus cycles per byte transfer
  localparam logic [1:0] SFR_CYCLES = 2'h2;
  localparam logic [1:0] MEM_CYCLES = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AREA_NONE = 2'b00,
    AREA_SFR  = 2'b01,
    AREA_RAM  = 2'b10,
    AREA_ROM  = 2'b11
  } ibac_area_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } ibac_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // Start address, any alignment
    logic              word;   // 1 = 16-bit access
    logic              write;  // 1 = write
    logic [WORD_W-1:0] wdata;  // Low byte goes first
  } ibac_cpu_req_t;

  typedef struct packed {
    logic              strobe; // Transfer in progress
    logic              write;  // Write transfer
    ibac_area_t        area;   // Target area
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [BYTE_W-1:0] wdata;  // Byte write data
  } ibac_byte_bus_t;

  localparam ibac_byte_bus_t BUS_IDLE = '{
    strobe: 1'b0, write: 1'b0, area: AREA_NONE,
    addr: 16'h0000, wdata: 8'h00};

  // Area that a byte address falls in
  function automatic ibac_area_t area_of(input logic [ADDR_W-1:0] a);
    if (a <= SFR_LAST) begin
      area_of = AREA_SFR;
    end else if (a >= RAM_BASE && a <= RAM_LAST) begin
      area_of = AREA_RAM;
    end else if (a >= ROM_BASE) begin
      area_of = AREA_ROM;
    end else begin
      area_of = AREA_NONE;
    end
  endfunction

endpackage

// >>> hdl/ibac_xfer_timer.sv
// Cycle counter that marks the last cycle of one byte transfer
`timescale 1ns/1ps
module ibac_xfer_timer (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic active,     // Transfer strobe
  input  wire logic isSfr,      // Target is the SFR area
  output logic      lastCycle   // Data moves at this edge
);

  logic [1:0] cnt_reg;          // Cycles already spent
  logic [1:0] need;             // Cycles this transfer needs

  assign need = isSfr ? ibac_pkg::SFR_CYCLES : ibac_pkg::MEM_CYCLES;
  assign lastCycle = active && (cnt_reg == need - 2'h1);

  // Count up, restart after each transfer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
    end else if (!active || lastCycle) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

endmodule

// >>> hdl/ibac_bus_ctrl.sv
// Internal bus sequencer with mode control register behind AXI4-Lite
`timescale 1ns/1ps

// How it works
// - SFR byte transfer lasts two clocks
// - ROM and RAM byte transfer lasts one
// - Eight-bit data path, one byte each
// - Word access becomes two byte transfers
// - Even word: even address, then plus one
// - Odd word: odd address, plus one, no fault
// - Only SFR, RAM and ROM are reachable
// - Writing trigger resets device, reads zero
// - Upper four mode bits read zero
module ibac_bus_ctrl (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // AXI4-Lite slave
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [31:0]            s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  // CPU side
  input  wire logic                   cpuValid,
  output logic                        cpuReady,
  input  wire ibac_pkg::ibac_cpu_req_t cpuReq,
  output logic                        cpuDone,
  output logic                        cpuFault,
  output logic [15:0]                 cpuRdata,
  // Internal byte bus
  output ibac_pkg::ibac_byte_bus_t    busOut,
  input  wire logic [7:0]             busRdata,
  output logic                        busLast,
  // Whole-device reset request
  output logic                        deviceResetReq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ibac_pkg::ibac_state_t    state_reg, state_next;   // Sequencer
  ibac_pkg::ibac_byte_bus_t bus_reg, bus_next;       // Byte bus drive
  ibac_pkg::ibac_cpu_req_t  req_reg, req_next;       // Held request
  ibac_pkg::ibac_area_t     area_reg, area_next;     // Last area used
  ibac_pkg::ibac_area_t     firstArea;               // Area of start
  ibac_pkg::ibac_area_t     secondArea;              // Area of byte two
  logic [15:0]              secAddr;                 // Start plus one
  logic [7:0]               lo_reg, lo_next;         // First byte read
  logic                     done_reg, done_next;     // Answer pulse
  logic                     fault_reg, fault_next;   // Answer fault
  logic [15:0]              rdat_reg, rdat_next;     // Answer data
  logic                     faultEvt;                // Unmapped access
  logic [7:0]               pmc_reg;                 // Mode control
  logic                     swRst_reg;               // Reset pulse
  logic                     faultSticky_reg;         // Status flag
  logic                     awHeld_reg, wHeld_reg;   // Captured halves
  logic [31:0]              awAddr_reg, wData_reg;   // Write payload
  logic [3:0]               wStrb_reg;               // Write lanes
  logic                     bvalid_reg, rvalid_reg;  // Responses
  logic [1:0]               bresp_reg, rresp_reg;    // Response codes
  logic [31:0]              rdata_reg;               // Read data
  logic                     doWrite;                 // Both halves here
  logic                     doRead;                  // Read address taken
  logic                     wrPmc, wrStat;           // Write decode
  logic                     rdPmc, rdStat;           // Read decode
  logic [7:0]               pmcView;                 // Mode read value
  logic [7:0]               statView;                // Status value

  // ----------------------------------------------------------------
  // Transfer timing
  // ----------------------------------------------------------------
  ibac_xfer_timer u_timer (
    .mclk      (mclk),
    .rst       (rst),
    .active    (bus_reg.strobe),
    .isSfr     (bus_reg.area == ibac_pkg::AREA_SFR),
    .lastCycle (busLast)
  );

  // ----------------------------------------------------------------
  // Sequencer decode
  // ----------------------------------------------------------------
  // reject addresses outside areas
  assign firstArea  = ibac_pkg::area_of(cpuReq.addr);
  assign secAddr    = req_reg.addr + ibac_pkg::ADDR_INC;
  assign secondArea = ibac_pkg::area_of(secAddr);
  assign cpuReady   = (state_reg == ibac_pkg::ST_IDLE) && !swRst_reg;

  // Next state of the byte sequencer
  always_comb begin
    state_next = state_reg;
    bus_next   = bus_reg;
    req_next   = req_reg;
    area_next  = area_reg;
    lo_next    = lo_reg;
    done_next  = 1'b0;
    fault_next = fault_reg;
    rdat_next  = rdat_reg;
    faultEvt   = 1'b0;
    unique case (state_reg)
      ibac_pkg::ST_IDLE: begin
        if (cpuValid && cpuReady) begin
          req_next = cpuReq;
          if (firstArea == ibac_pkg::AREA_NONE) begin
            // Unreachable area, answer at once
            done_next  = 1'b1;
            fault_next = 1'b1;
            rdat_next  = 16'h0000;
            faultEvt   = 1'b1;
          end else begin
            bus_next = '{strobe: 1'b1, write: cpuReq.write,
                         area: firstArea, addr: cpuReq.addr,
                         wdata: cpuReq.wdata[7:0]};
            state_next = ibac_pkg::ST_FIRST;
          end
        end
      end
      ibac_pkg::ST_FIRST: begin
        if (busLast) begin
          lo_next   = busRdata;
          area_next = bus_reg.area;
          // word goes on to byte two
          if (req_reg.word && secondArea != ibac_pkg::AREA_NONE) begin
            // next byte follows with no gap
            bus_next = '{strobe: 1'b1, write: req_reg.write,
                         area: secondArea, addr: secAddr,
                         wdata: req_reg.wdata[15:8]};
            state_next = ibac_pkg::ST_SECOND;
          end else begin
            // Byte access ends, or byte two unmapped
            bus_next   = ibac_pkg::BUS_IDLE;
            state_next = ibac_pkg::ST_IDLE;
            done_next  = 1'b1;
            fault_next = req_reg.word;
            faultEvt   = req_reg.word;
            rdat_next  = req_reg.word ? 16'h0000 : {8'h00, busRdata};
          end
        end
      end
      ibac_pkg::ST_SECOND: begin
        if (busLast) begin
          // Word assembled low byte first
          bus_next   = ibac_pkg::BUS_IDLE;
          area_next  = bus_reg.area;
          state_next = ibac_pkg::ST_IDLE;
          done_next  = 1'b1;
          fault_next = 1'b0;
          rdat_next  = {busRdata, lo_reg};
        end
      end
      default: begin
        // Illegal code, return to rest
        bus_next   = ibac_pkg::BUS_IDLE;
        state_next = ibac_pkg::ST_IDLE;
      end
    endcase
    if (swRst_reg) begin
      bus_next   = ibac_pkg::BUS_IDLE;
      state_next = ibac_pkg::ST_IDLE;
      done_next  = 1'b0;
      faultEvt   = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ibac_pkg::ST_IDLE;
      bus_reg   <= ibac_pkg::BUS_IDLE;
      req_reg   <= '0;
      area_reg  <= ibac_pkg::AREA_NONE;
      lo_reg    <= 8'h00;
      done_reg  <= 1'b0;
      fault_reg <= 1'b0;
      rdat_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      bus_reg   <= bus_next;
      req_reg   <= req_next;
      area_reg  <= area_next;
      lo_reg    <= lo_next;
      done_reg  <= done_next;
      fault_reg <= fault_next;
      rdat_reg  <= rdat_next;
    end
  end

  assign busOut   = bus_reg;
  assign cpuDone  = done_reg;
  assign cpuFault = fault_reg;
  assign cpuRdata = rdat_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready  = !wHeld_reg && !bvalid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign wrPmc   = doWrite && (awAddr_reg == ibac_pkg::PMC_OFFSET);
  assign wrStat  = doWrite && (awAddr_reg == ibac_pkg::STAT_OFFSET);

  // Capture address and data in either order
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 32'h0000_0000;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= {s_axi_awaddr[31:2], 2'h0};
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ibac_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wrPmc || wrStat) ? ibac_pkg::RESP_OKAY
                                      : ibac_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ----------------------------------------------------------------
  // Mode control and status
  // ----------------------------------------------------------------
  // Mode register, reserved low bits kept
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pmc_reg   <= ibac_pkg::PMC_RESET;
      swRst_reg <= 1'b0;
    end else begin
      swRst_reg <= wrPmc && wStrb_reg[0] && wData_reg[ibac_pkg::PMC_SWRST];
      if (swRst_reg) begin
        pmc_reg <= ibac_pkg::PMC_RESET;
      end else if (wrPmc && wStrb_reg[0]) begin
        pmc_reg <= {5'h00, wData_reg[ibac_pkg::PMC_RSV_MSB:0]};
      end
    end
  end

  // Sticky fault, new event beats clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      faultSticky_reg <= 1'b0;
    end else if (faultEvt) begin
      faultSticky_reg <= 1'b1;
    end else if (swRst_reg) begin
      faultSticky_reg <= 1'b0;
    end else if (wrStat && wStrb_reg[0] &&
                 wData_reg[ibac_pkg::STAT_FAULT]) begin
      faultSticky_reg <= 1'b0;
    end
  end

  assign deviceResetReq = swRst_reg;

  // upper bits and trigger read zero
  assign pmcView  = {5'h00, pmc_reg[ibac_pkg::PMC_RSV_MSB:0]};
  assign statView = {4'h0, faultSticky_reg, area_reg,
                     state_reg != ibac_pkg::ST_IDLE};

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;
  assign doRead = s_axi_arvalid && s_axi_arready;
  assign rdPmc  = {s_axi_araddr[31:2], 2'h0} == ibac_pkg::PMC_OFFSET;
  assign rdStat = {s_axi_araddr[31:2], 2'h0} == ibac_pkg::STAT_OFFSET;

  // Read answer one clock after address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= ibac_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (doRead) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= (rdPmc || rdStat) ? ibac_pkg::RESP_OKAY
                                      : ibac_pkg::RESP_SLVERR;
      rdata_reg  <= rdPmc  ? {24'h00_0000, pmcView}  :
                    rdStat ? {24'h00_0000, statView} : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule

// >>> tb/ibac_checker_assertions.sv
// Port-level checks of the bus sequencer
`timescale 1ns/1ps
module ibac_checker (
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic [31:0]              s_axi_awaddr,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [31:0]              s_axi_wdata,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_araddr,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     cpuValid,
  input wire logic                     cpuReady,
  input wire ibac_pkg::ibac_cpu_req_t  cpuReq,
  input wire logic                     cpuDone,
  input wire logic                     cpuFault,
  input wire logic [15:0]              cpuRdata,
  input wire ibac_pkg::ibac_byte_bus_t busOut,
  input wire logic [7:0]               busRdata,
  input wire logic                     busLast,
  input wire logic                     deviceResetReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------
  // Sequences
  // ------------
  sequence s_take;
    cpuValid && cpuReady;
  endsequence
  sequence s_sfr_open;
    busOut.strobe && busOut.area == ibac_pkg::AREA_SFR && !busLast;
  endsequence
  // ------------
  // Properties
  // ------------
  property p_sfr_two;
    s_sfr_open |=> busLast && $stable(busOut);
  endproperty
  a_sfr_two: assert property (p_sfr_two)
    else $error("SFR byte transfer not two cycles");
  property p_mem_one;
    busOut.strobe && busOut.area[1] |-> busLast;
  endproperty
  a_mem_one: assert property (p_mem_one)
    else $error("Memory byte transfer not one cycle");
  property p_next_byte;
    busOut.strobe && busLast ##1 busOut.strobe
      |-> busOut.addr == $past(busOut.addr) + 16'h0001;
  endproperty
  a_next_byte: assert property (p_next_byte)
    else $error("Second byte not at address plus one");
  property p_sfr_word;
    s_take ##0 (cpuReq.word && cpuReq.addr < ibac_pkg::SFR_LAST)
      |=> busOut.strobe [*4] ##1 (cpuDone && !busOut.strobe);
  endproperty
  a_sfr_word: assert property (p_sfr_word)
    else $error("SFR word not four busy cycles");
  property p_mem_word;
    s_take ##0 (cpuReq.word && cpuReq.addr >= ibac_pkg::RAM_BASE
      && cpuReq.addr < ibac_pkg::RAM_LAST)
      |=> busOut.strobe ##1 busOut.strobe ##1 cpuDone;
  endproperty
  a_mem_word: assert property (p_mem_word)
    else $error("Memory word not two byte transfers");
  property p_unmapped;
    s_take ##0 (cpuReq.addr > ibac_pkg::SFR_LAST
      && cpuReq.addr < ibac_pkg::RAM_BASE)
      |=> cpuDone && cpuFault && !busOut.strobe;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access reached the bus");
  property p_byte_read;
    s_take ##0 (!cpuReq.word && !cpuReq.write
      && cpuReq.addr >= ibac_pkg::ROM_BASE)
      |=> busLast ##1 (cpuDone && cpuRdata == {8'h00, $past(busRdata)});
  endproperty
  a_byte_read: assert property (p_byte_read)
    else $error("Byte read data not one lane");
  property p_swrst;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == ibac_pkg::PMC_OFFSET && s_axi_wdata[3]
      |-> ##2 deviceResetReq;
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("Reset trigger write gave no reset");
  property p_rst_abort;
    deviceResetReq |=> !deviceResetReq && !busOut.strobe && !cpuDone;
  endproperty
  a_rst_abort: assert property (p_rst_abort)
    else $error("Device reset did not abort traffic");
  property p_mode_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ibac_pkg::PMC_OFFSET
      |=> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("Mode register upper bits not zero");
endmodule

bind ibac_bus_ctrl ibac_checker u_chk (
  .mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rdata(s_axi_rdata), .cpuValid(cpuValid), .cpuReady(cpuReady),
  .cpuReq(cpuReq), .cpuDone(cpuDone), .cpuFault(cpuFault),
  .cpuRdata(cpuRdata), .busOut(busOut), .busRdata(busRdata),
  .busLast(busLast), .deviceResetReq(deviceResetReq));

// >>> tb/ibac_mem_model.sv
// Byte-wide memory that answers the internal bus
`timescale 1ns/1ps
module ibac_mem_model (
  input  wire logic                     mclk,
  input  wire ibac_pkg::ibac_byte_bus_t busOut,
  input  wire logic                     busLast,
  output logic [7:0]                    busRdata
);
  logic [7:0] mem [0:65535]; // Byte store
  logic [7:0] lastVal;       // Last value on the lane
  // Known pattern at start
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
    end
    lastVal = 8'h00;
  end
  assign busRdata = (busOut.strobe && !busOut.write && busLast) ?
                    mem[busOut.addr] : ~lastVal;
  // Store at the last cycle, lane toggles when idle
  always @(posedge mclk) begin
    lastVal <= busRdata;
    if (busOut.strobe && busOut.write && busLast) begin
      mem[busOut.addr] <= busOut.wdata;
    end
  end
endmodule

// >>> tb/tb_internal_bus_access_control.sv
// Self-checking bench of the bus sequencer
`timescale 1ns/1ps
module tb_internal_bus_access_control;
  logic        mclk, rst;
  int          n_errors, checked, seed, nRst;
  logic        awV, awR, wV, wR, bV, bRdy, arV, arR, rV, rRdy;
  logic [31:0] awA, wD, arA, rD, rdat;
  logic [3:0]  wS;
  logic [1:0]  bResp, rResp, resp;
  logic        cpuValid, cpuReady, cpuDone, cpuFault, busLast, devRst;
  logic [15:0] cpuRdata;
  logic [7:0]  busRdata;
  logic [7:0]  shadow [0:65535];
  logic [15:0] bases [0:7] = '{16'h0000, 16'h02FE, 16'h02FF, 16'h0300,
                               16'h0403, 16'h0BFF, 16'h4000, 16'hFFFF};
  ibac_pkg::ibac_cpu_req_t  cpuReq;
  ibac_pkg::ibac_byte_bus_t busOut;

  ibac_bus_ctrl dut (
    .mclk(mclk), .rst(rst), .s_axi_awvalid(awV), .s_axi_awready(awR),
    .s_axi_awaddr(awA), .s_axi_wvalid(wV), .s_axi_wready(wR),
    .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_bvalid(bV),
    .s_axi_bready(bRdy), .s_axi_bresp(bResp), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_araddr(arA), .s_axi_rvalid(rV),
    .s_axi_rready(rRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp),
    .cpuValid(cpuValid), .cpuReady(cpuReady), .cpuReq(cpuReq),
    .cpuDone(cpuDone), .cpuFault(cpuFault), .cpuRdata(cpuRdata),
    .busOut(busOut), .busRdata(busRdata), .busLast(busLast),
    .deviceResetReq(devRst));
  ibac_mem_model mem (.mclk(mclk), .busOut(busOut), .busLast(busLast),
                      .busRdata(busRdata));

  // Clock and device reset counter
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (devRst === 1'b1) nRst <= nRst + 1;

  // Bus cycles of one byte, zero if unmapped
  function automatic int cyc(input logic [15:0] a);
    if (a <= ibac_pkg::SFR_LAST) return 2;
    if (a >= ibac_pkg::RAM_BASE && a <= ibac_pkg::RAM_LAST) return 1;
    return (a >= ibac_pkg::ROM_BASE) ? 1 : 0;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One bounded clock step
  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 100) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
    int n;
    logic pa, pw, pb;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bRdy <= 1'b1;
    while (pa || pw || pb) begin
      tick(n);
      if (pa && awR === 1'b1) begin
        pa = 1'b0;
        awV <= 1'b0;
      end
      if (pw && wR === 1'b1) begin
        pw = 1'b0;
        wV <= 1'b0;
      end
      if (!pa && !pw && bV === 1'b1) begin
        pb = 1'b0;
        r = bResp;
      end
    end
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic pa;
    n = 0;
    pa = 1'b1;
    arA <= a;
    arV <= 1'b1;
    rRdy <= 1'b1;
    forever begin
      tick(n);
      if (pa && arR === 1'b1) begin
        pa = 1'b0;
        arV <= 1'b0;
      end else if (!pa && rV === 1'b1) begin
        break;
      end
    end
    d = rD;
    r = rResp;
  endtask

  // CPU access with latency, fault and data checks
  task automatic cpu_op(input logic [15:0] a, input logic w, wr,
                        input logic [15:0] d);
    int n, lat;
    logic [15:0] b, ed;
    logic fl;
    n = 0;
    b = a + 16'h0001;
    cpuReq <= '{addr: a, word: w, write: wr, wdata: d};
    cpuValid <= 1'b1;
    do tick(n); while (cpuReady !== 1'b1);
    cpuValid <= 1'b0;
    n = 0;
    do tick(n); while (cpuDone !== 1'b1);
    lat = 1 + cyc(a) + ((w && cyc(a) != 0) ? cyc(b) : 0);
    fl = cyc(a) == 0 || (w && cyc(b) == 0);
    ed = w ? {shadow[b], shadow[a]} : {8'h00, shadow[a]};
    check(32'(n), 32'(lat));
    check(32'(cpuFault), 32'(fl));
    if (!wr) check(32'(cpuRdata), fl ? 32'h0 : 32'(ed));
    if (wr && cyc(a) != 0) shadow[a] = d[7:0];
    if (wr && w && cyc(a) != 0 && cyc(b) != 0) shadow[b] = d[15:8];
  endtask

  initial begin
    rst = 1'b1;
    {awV, wV, bRdy, arV, rRdy, cpuValid} = 6'h00;
    {awA, wD, arA} = 96'h0;
    wS = 4'hF;
    cpuReq = '0;
    seed = 61;
    n_errors = 0;
    checked = 0;
    nRst = 0;
    for (int i = 0; i < 65536; i++) shadow[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // Mode register reset value, reserved bits, unmapped offset
    axi_rd(32'h4, rdat, resp);
    check(rdat, 32'h00);
    axi_wr(32'h4, 32'hF7, resp);
    check(32'(resp), 32'(ibac_pkg::RESP_OKAY));
    axi_rd(32'h4, rdat, resp);
    check(rdat, 32'h07);
    axi_rd(32'h10, rdat, resp);
    check(32'(resp), 32'(ibac_pkg::RESP_SLVERR));
    $display("Test registers finished");
    // Boundary addresses, every access kind
    for (int i = 0; i < 8; i++) begin
      cpu_op(bases[i], 1'b1, 1'b0, 16'h0000);
      cpu_op(bases[i], 1'b1, 1'b1, 16'hA55A ^ 16'(i));
      cpu_op(bases[i], 1'b1, 1'b0, 16'h0000);
      cpu_op(bases[i], 1'b0, 1'b0, 16'h0000);
      cpu_op(bases[i], 1'b0, 1'b1, 16'(i));
    end
    $display("Test corners finished");
    axi_rd(32'h8, rdat, resp);
    check(32'(rdat[3]), 32'h1);
    // Random traffic near the boundaries
    for (int i = 0; i < 120; i++) begin
      cpu_op(bases[$random(seed) & 7] + 16'($random(seed) & 3),
             1'($random(seed)), 1'($random(seed)), 16'($random(seed)));
    end
    $display("Test random finished");
    // Software reset clears mode register
    axi_wr(32'h4, 32'h05, resp);
    axi_wr(32'h4, 32'h0D, resp);
    repeat (2) @(posedge mclk);
    check(32'(nRst), 32'h1);
    axi_rd(32'h4, rdat, resp);
    check(rdat, 32'h00);
    $display("Test software reset finished");
    wrap_up();
  end
endmodule
